/* File: slm_pkg.sv */
// Shared constants, types and decode functions for the serial lane mapper.
package slm_pkg;
  localparam int SLM_DATA_W = 32;
  localparam int SLM_ADDR_W = 8;
  localparam int SLM_LANES = 8;
  localparam int SLM_MODE_W = 7;
  localparam int SLM_TEST_W = 4;
  localparam int SLM_PRBS_W = 31;
  // The sync-header error check is CRC-12 only; no CRC-3 path exists.
  localparam int SLM_CRC_BITS = 12;

  // Register byte offsets.
  localparam logic [SLM_ADDR_W-1:0] SLM_REG_MODE = 8'h00;
  localparam logic [SLM_ADDR_W-1:0] SLM_REG_TEST = 8'h04;
  localparam logic [SLM_ADDR_W-1:0] SLM_REG_SYNC = 8'h08;
  localparam logic [SLM_ADDR_W-1:0] SLM_REG_DEVCFG = 8'h0C;
  localparam logic [SLM_ADDR_W-1:0] SLM_REG_STATUS = 8'h10;

  // Link mode codes.
  localparam logic [SLM_MODE_W-1:0] SLM_LM_S8_A = 7'h05;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_S16_A = 7'h06;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_D8_A = 7'h07;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_D16_A = 7'h08;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_S4 = 7'h22;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_D4 = 7'h23;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_S8_B = 7'h2C;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_D8_B = 7'h2D;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_S16_B = 7'h32;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_D16_B = 7'h33;
  localparam logic [SLM_MODE_W-1:0] SLM_LM_FIRST_64B = 7'h22;

  // Test pattern codes.
  localparam logic [SLM_TEST_W-1:0] SLM_TP_OFF = 4'h0;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_PRBS7 = 4'h1;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_PRBS9 = 4'h2;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_PRBS15 = 4'h3;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_PRBS23 = 4'h4;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_PRBS31 = 4'h5;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_CLOCK = 4'h6;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_RAMP = 4'h7;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_TRANSPORT = 4'h8;
  localparam logic [SLM_TEST_W-1:0] SLM_TP_D215 = 4'h9;

  localparam logic [7:0] SLM_OCT_ZERO = 8'h00;
  localparam logic [7:0] SLM_OCT_ONES = 8'hFF;
  localparam logic [7:0] SLM_OCT_ALT = 8'hAA;
  localparam logic [1:0] SLM_RESP_OKAY = 2'b00;
  localparam logic [1:0] SLM_RESP_SLVERR = 2'b10;
  localparam logic [SLM_PRBS_W-1:0] SLM_PRBS_SEED_BASE = 31'h2A5A_5A00;

  typedef enum logic [1:0] {SLM_RAMP_IDLE = 2'b01, SLM_RAMP_RUN = 2'b10} slm_ramp_type;
  typedef logic [2*SLM_LANES-1:0][7:0] slm_samples_type;
  typedef struct packed {
    logic [SLM_LANES-1:0][7:0] link_b;
    logic [SLM_LANES-1:0][7:0] link_a;
  } slm_lanes_type;
  typedef struct packed {
    logic [SLM_MODE_W-1:0] link_mode_select;
    logic [SLM_TEST_W-1:0] test_pattern_select;
    logic fec_sel;
    logic cfg_pd;
  } slm_cfg_type;
  typedef struct packed {
    logic [2*SLM_LANES-1:0] lane_en;
    logic [12:0] rsvd;
    logic ramp_run;
    logic link_up;
    logic pd;
  } slm_status_type;

  localparam slm_cfg_type SLM_CFG_RESET = '{SLM_LM_S8_A, SLM_TP_OFF, 1'b0, 1'b0};

  // Number of lanes used on each link; zero for an unsupported mode.
  function automatic logic [3:0] slm_lane_count(input logic [SLM_MODE_W-1:0] m);
    if (m == SLM_LM_S4 || m == SLM_LM_D4) return 4'h2;
    if (m == SLM_LM_S8_A || m == SLM_LM_D8_A || m == SLM_LM_S8_B || m == SLM_LM_D8_B) return 4'h4;
    if (m == SLM_LM_S16_A || m == SLM_LM_D16_A || m == SLM_LM_S16_B || m == SLM_LM_D16_B)
      return 4'h8;
    return 4'h0;
  endfunction

  function automatic logic slm_is_single(input logic [SLM_MODE_W-1:0] m);
    return m == SLM_LM_S8_A || m == SLM_LM_S16_A || m == SLM_LM_S4 || m == SLM_LM_S8_B ||
      m == SLM_LM_S16_B;
  endfunction

  // The two feedback taps of the selected PRBS, upper then lower.
  function automatic logic [9:0] slm_prbs_taps(input logic [SLM_TEST_W-1:0] t);
    case (t)
      SLM_TP_PRBS9: return {5'd9, 5'd5};
      SLM_TP_PRBS15: return {5'd15, 5'd14};
      SLM_TP_PRBS23: return {5'd23, 5'd18};
      SLM_TP_PRBS31: return {5'd31, 5'd28};
      default: return {5'd7, 5'd6};
    endcase
  endfunction
endpackage

/* File: slm_prbs_lane.sv */
// One lane's PRBS generator, eight bits per clock, first bit in the MSB.
`timescale 1ns/1ps
`default_nettype none
module slm_prbs_lane
  import slm_pkg::*;
#(
  parameter logic [SLM_PRBS_W-1:0] SEED = SLM_PRBS_SEED_BASE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SLM_TEST_W-1:0] pattern_sel,
  output logic [7:0] octet_q
);
  logic [SLM_PRBS_W-1:0] hist_q;
  logic [SLM_PRBS_W-1:0] hist_d;
  logic [SLM_TEST_W-1:0] sel_q;
  logic [7:0] oct_d;
  wire [9:0] taps = slm_prbs_taps(pattern_sel);

  // Bit 0 of the history is the newest bit; each new bit XORs two older ones.
  always_comb begin : step
    logic [SLM_PRBS_W-1:0] h;
    h = hist_q;
    oct_d = SLM_OCT_ZERO;
    for (int i = 0; i < 8; i++) begin
      oct_d[7-i] = h[taps[9:5]-5'd1] ^ h[taps[4:0]-5'd1];
      h = {h[SLM_PRBS_W-2:0], oct_d[7-i]};
    end
    hist_d = h;
  end

  // A change of sequence reseeds, so a short window can never start all zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_q <= SEED;
      sel_q <= SLM_TP_OFF;
      octet_q <= SLM_OCT_ZERO;
    end else begin
      sel_q <= pattern_sel;
      hist_q <= (pattern_sel != sel_q) ? SEED : hist_d;
      octet_q <= oct_d;
    end
  end
endmodule // slm_prbs_lane
`default_nettype wire

/* File: slm_axil_regs.sv */
// AXI4-Lite register slave holding the mapper's configuration.
`timescale 1ns/1ps
`default_nettype none
module slm_axil_regs
  import slm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SLM_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [SLM_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [SLM_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [SLM_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire slm_status_type status,
  output slm_cfg_type cfg_q
);
  logic aw_q, ar_q, b_q, r_q;
  logic [1:0] bresp_q, rresp_q;
  logic [SLM_DATA_W-1:0] rdata_q;
  slm_cfg_type cfg_d;

  // Ready pulses one cycle after both address and data are seen.
  wire wr_go = awvalid && wvalid && !aw_q && !b_q;
  wire rd_go = arvalid && !ar_q && !r_q;
  wire wr_mode = awaddr == SLM_REG_MODE;
  wire wr_test = awaddr == SLM_REG_TEST;
  wire wr_sync = awaddr == SLM_REG_SYNC;
  wire wr_dev = awaddr == SLM_REG_DEVCFG;
  wire wr_hit = wr_mode || wr_test || wr_sync || wr_dev;
  wire wr_hit_r = araddr == SLM_REG_MODE || araddr == SLM_REG_TEST ||
    araddr == SLM_REG_SYNC || araddr == SLM_REG_DEVCFG;
  wire rd_hit = wr_hit_r || araddr == SLM_REG_STATUS;

  // Fields live in the low byte, so only its strobe matters.
  assign cfg_d.link_mode_select = (wr_mode && wstrb[0]) ? wdata[SLM_MODE_W-1:0]
    : cfg_q.link_mode_select;
  assign cfg_d.test_pattern_select = (wr_test && wstrb[0]) ? wdata[SLM_TEST_W-1:0]
    : cfg_q.test_pattern_select;
  assign cfg_d.fec_sel = (wr_sync && wstrb[0]) ? wdata[0] : cfg_q.fec_sel;
  assign cfg_d.cfg_pd = (wr_dev && wstrb[0]) ? wdata[0] : cfg_q.cfg_pd;

  // Read selection; unmapped words read zero.
  wire [SLM_DATA_W-1:0] rd_val =
    (araddr == SLM_REG_MODE) ? SLM_DATA_W'(cfg_q.link_mode_select) :
    (araddr == SLM_REG_TEST) ? SLM_DATA_W'(cfg_q.test_pattern_select) :
    (araddr == SLM_REG_SYNC) ? SLM_DATA_W'(cfg_q.fec_sel) :
    (araddr == SLM_REG_DEVCFG) ? SLM_DATA_W'(cfg_q.cfg_pd) :
    (araddr == SLM_REG_STATUS) ? SLM_DATA_W'(status) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      ar_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      bresp_q <= SLM_RESP_OKAY;
      rresp_q <= SLM_RESP_OKAY;
      rdata_q <= '0;
      cfg_q <= SLM_CFG_RESET;
    end else begin
      aw_q <= wr_go;
      ar_q <= rd_go;
      if (aw_q) begin
        b_q <= 1'b1;
        bresp_q <= wr_hit ? SLM_RESP_OKAY : SLM_RESP_SLVERR;
        cfg_q <= cfg_d;
      end else if (bready) begin
        b_q <= 1'b0;
      end
      if (ar_q) begin
        r_q <= 1'b1;
        rresp_q <= rd_hit ? SLM_RESP_OKAY : SLM_RESP_SLVERR;
        rdata_q <= rd_val;
      end else if (rready) begin
        r_q <= 1'b0;
      end
    end
  end

  assign awready = aw_q;
  assign wready = aw_q;
  assign bvalid = b_q;
  assign bresp = bresp_q;
  assign arready = ar_q;
  assign rvalid = r_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
endmodule // slm_axil_regs
`default_nettype wire

/* File: slm_lane_mapper.sv */
// Lane mapper and serializer test-pattern source for links A and B.
// Summary of operation
// - 8-lane single: even samples A, odd B.
// - 16-lane single: even samples A, odd B.
// - 8-lane dual: channel sample n on lane n.
// - 16-lane dual: channel sample n on lane n.
// - Mode 34: S0,S2 on A; S1,S3 on B.
// - Mode 35: A0,A1 on A; B0,B1 on B.
// - Error detection uses CRC-12 only, never CRC-3.
// - Sync mode register picks CRC or FEC.
// - Power-down from pin or config disables drivers.
// - Test pattern chosen by field; lanes follow mode.
// - PRBS bypasses transport and link layers.
// - Five PRBS polynomials, XOR of two taps.
// - Each lane's PRBS starts at unique phase.
// - Clock pattern: eight ones, eight zeros, raw.
// - Ramp keeps link layer, starts after link up.
// - Ramp counts 0x00 to 0xFF on all lanes.
// - Transport: lane k sends k, then 0xFF-k.
// - D21.5 gives alternating bits, both encodings.
// - Samples go MSB first; no tail bits.
// - Lowest lanes used; higher lanes powered down.
`timescale 1ns/1ps
`default_nettype none
module slm_lane_mapper
  import slm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [SLM_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [SLM_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [SLM_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [SLM_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire slm_samples_type samples,
  input wire logic power_down_pin,
  input wire logic link_up,
  output slm_lanes_type lanes_q,
  output logic [2*SLM_LANES-1:0] lane_en_q,
  output logic lane_raw_q,
  output logic crc12_en_q,
  output logic fec_en_q,
  output logic dev_pd_q
);
  slm_cfg_type cfg;
  slm_status_type status;
  slm_lanes_type lanes_d;
  slm_lanes_type map;
  slm_lanes_type prbs;
  slm_lanes_type trans;
  slm_ramp_type ramp_state_q;
  logic [7:0] ramp_q;
  logic frame_q;
  logic [2*SLM_LANES-1:0] lane_en_d;

  // Register slave; configuration steers everything below.
  slm_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .status(status),
    .cfg_q(cfg)
  );

  // Decoded configuration.
  wire [SLM_TEST_W-1:0] tsel = cfg.test_pattern_select;
  wire [SLM_MODE_W-1:0] mode = cfg.link_mode_select;
  wire pd_req = power_down_pin || cfg.cfg_pd;
  wire [3:0] n_lanes = slm_lane_count(mode);
  wire single = slm_is_single(mode);
  wire is_64b = mode >= SLM_LM_FIRST_64B;
  wire prbs_on = tsel >= SLM_TP_PRBS7 && tsel <= SLM_TP_PRBS31;
  wire clk_on = tsel == SLM_TP_CLOCK;
  wire ramp_on = tsel == SLM_TP_RAMP;
  wire trans_on = tsel == SLM_TP_TRANSPORT;
  wire d215_on = tsel == SLM_TP_D215;
  wire [7:0] clk_oct = frame_q ? SLM_OCT_ZERO : SLM_OCT_ONES;

  // Raw patterns skip scrambler and encoder; the alternating octet gives
  // 1010 on the wire whichever line code the mode uses.
  wire raw_d = prbs_on || clk_on || d215_on;

  // Per-lane mapping, pattern sources and selection for both links.
  genvar g;
  generate
    for (g = 0; g < SLM_LANES; g++) begin : g_lane
      // Single channel interleaves samples across links; dual keeps them apart.
      assign map.link_a[g] = single ? samples[2*g] : samples[g];
      assign map.link_b[g] = single ? samples[2*g+1] : samples[SLM_LANES+g];
      // Transport octets count up in frame 0 and down from 0xFF in frame 1.
      assign trans.link_a[g] = frame_q ? SLM_OCT_ONES - 8'(g) : 8'(g);
      assign trans.link_b[g] = trans.link_a[g];
      // Distinct non-zero seeds give every lane its own phase.
      slm_prbs_lane #(.SEED(SLM_PRBS_SEED_BASE | SLM_PRBS_W'(g + 1))) u_prbs_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .pattern_sel(tsel),
        .octet_q(prbs.link_a[g])
      );
      slm_prbs_lane #(.SEED(SLM_PRBS_SEED_BASE | SLM_PRBS_W'(g + 1 + SLM_LANES))) u_prbs_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .pattern_sel(tsel),
        .octet_q(prbs.link_b[g])
      );
      // Enables depend on the mode and power-down only, never on the pattern.
      assign lane_en_d[g] = !pd_req && (4'(g) < n_lanes);
      assign lane_en_d[SLM_LANES+g] = lane_en_d[g];
      // Samples pass whole, MSB in bit 7; 8-bit samples leave no tail bits.
      assign lanes_d.link_a[g] = !lane_en_d[g] ? SLM_OCT_ZERO :
        prbs_on ? prbs.link_a[g] : clk_on ? clk_oct : ramp_on ? ramp_q :
        trans_on ? trans.link_a[g] : d215_on ? SLM_OCT_ALT : map.link_a[g];
      assign lanes_d.link_b[g] = !lane_en_d[g] ? SLM_OCT_ZERO :
        prbs_on ? prbs.link_b[g] : clk_on ? clk_oct : ramp_on ? ramp_q :
        trans_on ? trans.link_b[g] : d215_on ? SLM_OCT_ALT : map.link_b[g];
    end
  endgenerate

  // Ramp waits for the link layer to be up, then counts and wraps.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_state_q <= SLM_RAMP_IDLE;
      ramp_q <= SLM_OCT_ZERO;
    end else begin
      case (ramp_state_q)
        SLM_RAMP_IDLE: begin
          ramp_q <= SLM_OCT_ZERO;
          if (ramp_on && link_up) begin
            ramp_state_q <= SLM_RAMP_RUN;
          end
        end
        SLM_RAMP_RUN: begin
          // Leaving the run clears the count at once, so no stale step leaks out.
          if (!ramp_on || !link_up) begin
            ramp_state_q <= SLM_RAMP_IDLE;
            ramp_q <= SLM_OCT_ZERO;
          end else begin
            ramp_q <= ramp_q + 8'h01;
          end
        end
        default: begin
          ramp_state_q <= SLM_RAMP_IDLE;
        end
      endcase
    end
  end

  // One octet per clock: frame phase doubles as the clock-pattern half.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= !frame_q;
    end
  end

  // Output stage; every lane and link-control output leaves the block from these flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lanes_q <= '0;
      lane_en_q <= '0;
      lane_raw_q <= 1'b0;
      crc12_en_q <= 1'b0;
      fec_en_q <= 1'b0;
      dev_pd_q <= 1'b0;
    end else begin
      lanes_q <= lanes_d;
      lane_en_q <= lane_en_d;
      lane_raw_q <= raw_d && !pd_req;
      crc12_en_q <= is_64b && !cfg.fec_sel && !pd_req;
      fec_en_q <= is_64b && cfg.fec_sel && !pd_req;
      dev_pd_q <= pd_req;
    end
  end

  // Status word read back by software.
  assign status.lane_en = lane_en_q;
  assign status.rsvd = '0;
  assign status.ramp_run = ramp_state_q == SLM_RAMP_RUN;
  assign status.link_up = link_up;
  assign status.pd = dev_pd_q;

  // Checks on the transmitted lanes.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire normal = tsel == SLM_TP_OFF && !pd_req;

  chk_pd_drivers_off: assert property (pd_req |=> lane_en_q == '0 && lanes_q == '0)
    else $error("Lanes active during power-down.");
  chk_single8_map: assert property (normal && (mode == SLM_LM_S8_A || mode == SLM_LM_S8_B)
    |=> lanes_q.link_a[3] == $past(samples[6]) && lanes_q.link_b[3] == $past(samples[7])
    && lane_en_q == 16'h0F0F)
    else $error("Single 8-lane mapping wrong.");
  chk_single16_map: assert property (normal && (mode == SLM_LM_S16_A || mode == SLM_LM_S16_B)
    |=> lanes_q.link_a[7] == $past(samples[14]) && lanes_q.link_b[5] == $past(samples[11]))
    else $error("Single 16-lane mapping wrong.");
  chk_dual8_map: assert property (normal && (mode == SLM_LM_D8_A || mode == SLM_LM_D8_B)
    |=> lanes_q.link_b[2] == $past(samples[10]) && lanes_q.link_a[4] == '0)
    else $error("Dual 8-lane mapping wrong.");
  chk_dual16_map: assert property (normal && (mode == SLM_LM_D16_A || mode == SLM_LM_D16_B)
    |=> lanes_q.link_a[7] == $past(samples[7]) && lanes_q.link_b[7] == $past(samples[15]))
    else $error("Dual 16-lane mapping wrong.");
  chk_four_lane_map: assert property (normal && mode == SLM_LM_S4
    |=> lanes_q.link_a[1] == $past(samples[2]) && lanes_q.link_b[1] == $past(samples[3])
    && lane_en_q == 16'h0303)
    else $error("Mode 34 mapping wrong.");
  chk_dual4_map: assert property (normal && mode == SLM_LM_D4
    |=> lanes_q.link_b[1] == $past(samples[9]) && lanes_q.link_a[2] == '0)
    else $error("Mode 35 mapping wrong.");
  chk_sync_header: assert property (!pd_req && is_64b
    |=> crc12_en_q == !$past(cfg.fec_sel) && fec_en_q == $past(cfg.fec_sel))
    else $error("Sync header mode wrong.");
  chk_test_lanes: assert property (!pd_req && tsel != SLM_TP_OFF
    && (mode == SLM_LM_D16_A || mode == SLM_LM_D16_B) |=> lane_en_q == 16'hFFFF)
    else $error("Test pattern changed lane count.");
  chk_prbs_raw: assert property (prbs_on && !pd_req |=> lane_raw_q)
    else $error("PRBS not bypassing the link layer.");

  // A steady clock pattern flips between all ones and all zeros.
  sequence clk_steady;
    (clk_on && !pd_req && n_lanes != 4'h0)[*2];
  endsequence
  chk_clock_pattern: assert property (clk_steady |=>
    lanes_q.link_a[0] == ~$past(lanes_q.link_a[0]) && lane_raw_q)
    else $error("Clock pattern broken.");

  // Ramp stays at zero until link up, then steps by one each octet.
  chk_ramp_start: assert property (!link_up ##1 !link_up |-> ramp_q == SLM_OCT_ZERO)
    else $error("Ramp ran before link up.");
  sequence ramp_steady;
    (ramp_state_q == SLM_RAMP_RUN)[*2];
  endsequence
  chk_ramp_step: assert property (ramp_steady |-> ramp_q == $past(ramp_q) + 8'h01)
    else $error("Ramp did not increment.");

  // Transport frames alternate k and 0xFF-k on an enabled lane.
  chk_transport: assert property ((trans_on && !pd_req && n_lanes != 4'h0)[*2]
    |=> lanes_q.link_b[0] == ~$past(lanes_q.link_b[0])
    && (lanes_q.link_b[0] == SLM_OCT_ZERO || lanes_q.link_b[0] == SLM_OCT_ONES))
    else $error("Transport pattern broken.");
  chk_d215_alt: assert property (d215_on && !pd_req && n_lanes != 4'h0
    |=> lanes_q.link_a[0] == SLM_OCT_ALT && lane_raw_q)
    else $error("D21.5 pattern wrong.");
endmodule // slm_lane_mapper
`default_nettype wire

/* File: slm_rx_model.sv */
// Far-side link receiver model that rebuilds the link after power-down.
`timescale 1ns/1ps
`default_nettype none
module slm_rx_model
  import slm_pkg::*;
#(
  parameter int FLUSH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_en,
  input wire logic dev_pd_q,
  output logic link_up
);
  logic [7:0] wait_q;

  // The link only comes back once stale pipeline data has had time to drain.
  always_ff @(posedge aclk) begin
    if (!aresetn || !link_en || dev_pd_q) begin
      wait_q <= 8'h00;
      link_up <= 1'b0;
    end else if (wait_q != 8'(FLUSH)) begin
      wait_q <= wait_q + 8'h01;
    end else begin
      link_up <= 1'b1;
    end
  end
endmodule // slm_rx_model
`default_nettype wire

/* File: serdes_lane_mapper_test_patterns_tb_top.sv */
// Self-checking bench for the serial lane mapper and its test patterns.
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_mapper_test_patterns_tb_top
  import slm_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic power_down_pin = 0, link_en = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  slm_samples_type samples = '0;
  logic awready, wready, bvalid, arready, rvalid, lane_raw_q, crc12_en_q, fec_en_q;
  logic dev_pd_q, link_up;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  slm_lanes_type lq;
  logic [15:0] lane_en_q;
  int miscompares = 0, num_checks = 0, cyc = 0;
  logic [6:0] mds [10] = '{7'h05, 7'h2C, 7'h07, 7'h2D, 7'h22, 7'h23, 7'h06, 7'h32, 7'h08, 7'h33};
  int cnt [10] = '{4, 4, 4, 4, 2, 2, 8, 8, 8, 8};
  bit sng [10] = '{1, 1, 0, 0, 1, 0, 1, 1, 0, 0};
  int hi [5] = '{7, 9, 15, 23, 31};
  int lo [5] = '{6, 5, 14, 18, 28};

  slm_lane_mapper dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .samples(samples),
    .power_down_pin(power_down_pin), .link_up(link_up), .lanes_q(lq), .lane_en_q(lane_en_q),
    .lane_raw_q(lane_raw_q), .crc12_en_q(crc12_en_q), .fec_en_q(fec_en_q), .dev_pd_q(dev_pd_q)
  );
  slm_rx_model rx (
    .aclk(aclk), .aresetn(aresetn), .link_en(link_en), .dev_pd_q(dev_pd_q), .link_up(link_up)
  );

  // Free-running 40 MHz clock.
  always #12.5 aclk = ~aclk;

  // A hang anywhere ends the run as a mismatch rather than stalling forever.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Each channel is released on the edge where its own ready is seen.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask

  // The pattern is only switched with the link held down.
  task automatic set_tp(input logic [3:0] t);
    logic [1:0] r;
    @(posedge aclk);
    link_en <= 1'b0;
    repeat (2) @(posedge aclk);
    axw(SLM_REG_TEST, {28'h000_0000, t}, r);
    link_en <= 1'b1;
    repeat (4) @(negedge aclk);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [63:0] bits;
    logic [7:0] o1;
    int e;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(SLM_REG_MODE, d, r);
    chk("mode_rst", 32'h0000_0005, d);
    axr(8'h40, d, r);
    chk("rd_unmapped", 32'(SLM_RESP_SLVERR), 32'(r));
    axw(SLM_REG_STATUS, 32'h0000_0001, r);
    chk("wr_status", 32'(SLM_RESP_SLVERR), 32'(r));
    $display("Test registers done");
    for (int m = 0; m < 10; m++) begin
      @(posedge aclk);
      for (int i = 0; i < 16; i++) samples[i] <= 8'(i * 17 + m * 3 + 1);
      axw(SLM_REG_MODE, {25'h000_0000, mds[m]}, r);
      repeat (2) @(negedge aclk);
      e = (1 << cnt[m]) - 1;
      chk("lane_en", {16'h0000, 8'(e), 8'(e)}, 32'(lane_en_q));
      for (int k = 0; k < cnt[m]; k++) begin
        o1 = sng[m] ? samples[2 * k] : samples[k];
        chk("link_a", 32'(o1), 32'(lq.link_a[k]));
        o1 = sng[m] ? samples[2 * k + 1] : samples[8 + k];
        chk("link_b", 32'(o1), 32'(lq.link_b[k]));
      end
    end
    $display("Test lane mapping done");
    axw(SLM_REG_SYNC, 32'h0000_0000, r);
    repeat (2) @(negedge aclk);
    chk("crc12", 32'h2, 32'({crc12_en_q, fec_en_q}));
    axw(SLM_REG_SYNC, 32'h0000_0001, r);
    repeat (2) @(negedge aclk);
    chk("fec", 32'h2, 32'({fec_en_q, crc12_en_q}));
    $display("Test sync header done");
    for (int t = 0; t < 5; t++) begin
      set_tp(4'(t + 1));
      chk("prbs_raw", 32'h1, 32'(lane_raw_q));
      chk("prbs_en", 32'h0000_FFFF, 32'(lane_en_q));
      e = 0;
      for (int i = 0; i < 8; i++) begin
        bits = {bits[55:0], lq.link_a[1]};
        if (lq.link_a[1] === lq.link_b[1]) e++;
        @(negedge aclk);
      end
      chk("prbs_phase", 32'h0, 32'(e == 8));
      chk("prbs_live", 32'h1, 32'(bits != 64'h0));
      e = 0;
      for (int n = hi[t]; n < 64; n++)
        if (bits[63 - n] !== (bits[63 - n + lo[t]] ^ bits[63 - n + hi[t]])) e++;
      chk("prbs_poly", 32'h0, 32'(e));
    end
    set_tp(SLM_TP_CLOCK);
    o1 = lq.link_a[0];
    chk("clk_val", 32'h1, 32'(o1 === 8'hFF || o1 === 8'h00));
    @(negedge aclk);
    chk("clk_pair", 32'(o1 ^ 8'hFF), 32'(lq.link_a[0]));
    chk("clk_raw", 32'h1, 32'(lane_raw_q));
    set_tp(SLM_TP_RAMP);
    chk("ramp_wait", 32'h0, 32'(lq.link_a[0]));
    while (link_up !== 1'b1) @(negedge aclk);
    repeat (3) @(negedge aclk);
    o1 = lq.link_a[0] + 8'h01;
    @(negedge aclk);
    for (int k = 0; k < 8; k++) begin
      chk("ramp_a", 32'(o1), 32'(lq.link_a[k]));
      chk("ramp_b", 32'(o1), 32'(lq.link_b[k]));
    end
    chk("ramp_raw", 32'h0, 32'(lane_raw_q));
    for (int i = 0; i < 300 && lq.link_a[0] !== 8'hFF; i++) @(negedge aclk);
    @(negedge aclk);
    chk("ramp_wrap", 32'h0, 32'(lq.link_a[0]));
    set_tp(SLM_TP_TRANSPORT);
    o1 = (lq.link_a[0] === 8'hFF) ? 8'hFF : 8'h00;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 8; k++) begin
        chk("tport_a", 32'(o1 ^ 8'(k)), 32'(lq.link_a[k]));
        chk("tport_b", 32'(o1 ^ 8'(k)), 32'(lq.link_b[k]));
      end
      o1 = ~o1;
      @(negedge aclk);
    end
    set_tp(SLM_TP_D215);
    chk("d215", 32'h0000_00AA, 32'(lq.link_b[3]));
    chk("d215_raw", 32'h1, 32'(lane_raw_q));
    set_tp(SLM_TP_OFF);
    $display("Test patterns done");
    @(posedge aclk);
    power_down_pin <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("pd_en", 32'h0, 32'(lane_en_q));
    chk("pd_flag", 32'h1, 32'(dev_pd_q));
    chk("pd_fec", 32'h0, 32'(fec_en_q));
    @(posedge aclk);
    power_down_pin <= 1'b0;
    axw(SLM_REG_DEVCFG, 32'h0000_0001, r);
    repeat (2) @(negedge aclk);
    chk("cfg_pd_en", 32'h0, 32'(lane_en_q));
    axr(SLM_REG_STATUS, d, r);
    chk("status_pd", 32'h1, 32'(d[0]));
    axw(SLM_REG_DEVCFG, 32'h0000_0000, r);
    while (link_up !== 1'b1) @(negedge aclk);
    chk("pd_back", 32'h0000_FFFF, 32'(lane_en_q));
    $display("Test power down done");
    finish_test();
  end
endmodule // serdes_lane_mapper_test_patterns_tb_top
`default_nettype wire
